// [pkg/ssc_consts.svh]
// Named constants for the stepper sequencer control block.
// Assumes inclusion by bare name from the package and the bench.
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define SSC_CLK_HZ 20000000
`define SSC_HOLD_TIME_US 1000
`define SSC_HOLD_CYCLES ((`SSC_HOLD_TIME_US * `SSC_CLK_HZ) / 1000000)

// ----------------------------------------------------------------------
// Register byte offsets and fields
// ----------------------------------------------------------------------
`define SSC_ADDR_CTRL 12'h000
`define SSC_ADDR_STATUS 12'h004
`define SSC_ADDR_STEPCNT 12'h008
`define SSC_CTRL_HOME_BIT 0
`define SSC_CTRL_CNTCLR_BIT 1
`define SSC_CTRL_RESET 2'h0

// ----------------------------------------------------------------------
// Sequencer encodings
// ----------------------------------------------------------------------
`define SSC_MODE_SLEEP 3'h7
`define SSC_MODE_HALF 3'h1
`define SSC_HOME_POS 3'h0
`define SSC_STEP_FULL 3'h2
`define SSC_STEP_HALF 3'h1
`define SSC_PHASE_OFF 4'h0
`define SSC_CNT_RESET 16'h0000

`endif

// [pkg/ssc_pkg.sv]
// Types shared by the stepper sequencer control files.
// Assumes ssc_consts.svh is on the include path.
`include "ssc_consts.svh"

package ssc_pkg;

   // Sequencer operating state, Gray coded along active-hold-coast.
   typedef enum logic [1:0] {
      SSC_ACTIVE = 2'h0,
      SSC_HOLD = 2'h1,
      SSC_COAST_REF = 2'h3,
      SSC_COAST_PINS = 2'h2
   } ssc_state_t;

   // Logic input pins, carried together through the synchroniser.
   typedef struct packed {
      logic step_clock;
      logic reset_pin;
      logic direction_select;
      logic [2:0] excitation_mode_sel;
      logic hold_chop_align;
      logic ref_above_threshold;
      logic fault;
   } ssc_pins_t;

endpackage

// [src/ssc_sync.sv]
// Two-stage synchroniser for the asynchronous pin group.
// Assumes pins change independently of pclk; only stage two is read.
`timescale 1ns/1ps
`default_nettype none

module ssc_sync
   import ssc_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Raw and synchronised pins.
   input wire ssc_pins_t pins_in,
   output var ssc_pins_t pins_out
);

   // First stage, read only by the second stage.
   ssc_pins_t meta_reg;
   ssc_pins_t meta_next;
   // Second stage, safe for logic.
   ssc_pins_t sync_reg;
   ssc_pins_t sync_next;

   // Next values simply shift the pins one stage along.
   always_comb begin
      meta_next = pins_in;
      sync_next = meta_reg;
   end

   // Both stages clear low at reset, except the step clock, which starts high.
   // A step pin resting high through reset then gives no false rising edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '{step_clock: 1'b1, excitation_mode_sel: 3'h0, default: 1'b0};
         sync_reg <= '{step_clock: 1'b1, excitation_mode_sel: 3'h0, default: 1'b0};
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign pins_out = sync_reg;

endmodule

`default_nettype wire

// [src/ssc_phase_dec.sv]
// Registered half-step table turning a sequencer position into drives.
// Assumes position and enable come from logic on pclk.
`timescale 1ns/1ps
`default_nettype none

module ssc_phase_dec
   import ssc_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Position and output enable.
   input wire logic [2:0] position,
   input wire logic drive_en,
   // Phase drives: A, B, A-bar, B-bar from bit 0 upward.
   output logic [3:0] phase_out
);

   // Registered drive pattern and its next value.
   logic [3:0] phase_reg;
   logic [3:0] phase_next;

   // Look up the pattern; a disabled output coasts with all drives off.
   always_comb begin
      phase_next = `SSC_PHASE_OFF;
      if (drive_en) begin
         unique case (position)
            3'h0: phase_next = 4'h1;
            3'h1: phase_next = 4'h3;
            3'h2: phase_next = 4'h2;
            3'h3: phase_next = 4'h6;
            3'h4: phase_next = 4'h4;
            3'h5: phase_next = 4'hC;
            3'h6: phase_next = 4'h8;
            3'h7: phase_next = 4'h9;
         endcase
      end
   end

   // Drives start switched off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= `SSC_PHASE_OFF;
      end else begin
         phase_reg <= phase_next;
      end
   end

   assign phase_out = phase_reg;

endmodule

`default_nettype wire

// [src/ssc_top.sv]
// Step sequencer control logic with an APB register slave.
// Assumes pins arrive asynchronously and the reference comparator is digital.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ssc_top
   import ssc_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = `SSC_HOLD_CYCLES
)(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Logic input pins.
   input wire logic step_clock_in,
   input wire logic reset_pin_in,
   input wire logic direction_select_in,
   input wire logic [2:0] excitation_mode_sel_in,
   input wire logic hold_chop_align_in,
   input wire logic reference_and_disable_input,
   input wire logic fault_in,
   // Power stage and monitor outputs.
   output logic [3:0] phase_drive,
   output logic chop_sync_en,
   output logic supply_reduce,
   output logic step_position_out_n,
   output logic alarm_out_n
);

   // ----------------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------------

   // Raw and synchronised pin groups.
   ssc_pins_t pins_raw;
   ssc_pins_t pins_s;

   always_comb begin
      pins_raw.step_clock = step_clock_in;
      pins_raw.reset_pin = reset_pin_in;
      pins_raw.direction_select = direction_select_in;
      pins_raw.excitation_mode_sel = excitation_mode_sel_in;
      pins_raw.hold_chop_align = hold_chop_align_in;
      pins_raw.ref_above_threshold = reference_and_disable_input;
      pins_raw.fault = fault_in;
   end

   ssc_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pins_in(pins_raw),
      .pins_out(pins_s)
   );

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------

   // Step size in half-step units for the selected excitation mode.
   function automatic logic [2:0] step_size(input logic [2:0] mode);
      step_size = (mode == `SSC_MODE_HALF) ? `SSC_STEP_HALF : `SSC_STEP_FULL;
   endfunction

   // Position after one step in the chosen direction, wrapping round.
   function automatic logic [2:0] step_pos(input logic [2:0] pos, input logic dir, input logic [2:0] mode);
      step_pos = dir ? 3'(pos - step_size(mode)) : 3'(pos + step_size(mode));
   endfunction

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------

   ssc_state_t state_reg;             // Operating state.
   ssc_state_t state_next;
   logic [2:0] pos_reg;               // Excitation position.
   logic [2:0] pos_next;
   logic step_prev_reg;               // Step pin one cycle ago, for edges.
   logic step_prev_next;
   logic [15:0] idle_reg;             // Cycles since the last accepted step edge.
   logic [15:0] idle_next;
   logic [15:0] stepcnt_reg;          // Accepted step count.
   logic [15:0] stepcnt_next;
   logic por_done_reg;                // Low only in the first cycle after reset.
   logic soft_home;                   // Software homing pulse.
   logic cnt_clear;                   // Software count clear pulse.
   logic step_rise;                   // Active step edge seen this cycle.
   logic mode_sleep;                  // Mode pins select the sleep pattern.
   logic home_req;                    // Any homing request.
   logic step_take;                   // A step edge that the sequencer accepts.
   logic drive_en;                    // Power outputs enabled.

   always_comb begin
      step_rise = pins_s.step_clock & ~step_prev_reg;
      mode_sleep = (pins_s.excitation_mode_sel == `SSC_MODE_SLEEP);
      home_req = pins_s.reset_pin | soft_home;
      step_take = step_rise & ~mode_sleep & ~home_req;
      drive_en = ~mode_sleep & ~pins_s.ref_above_threshold;
   end

   // Next sequencer state; homing beats stepping, sleep beats all state changes but not homing.
   always_comb begin
      step_prev_next = pins_s.step_clock;
      pos_next = pos_reg;
      idle_next = idle_reg;
      stepcnt_next = stepcnt_reg;
      state_next = state_reg;
      if (home_req) begin
         pos_next = `SSC_HOME_POS;
      end else if (step_take) begin
         pos_next = step_pos(pos_reg, pins_s.direction_select, pins_s.excitation_mode_sel);
      end
      // Idle counter saturates at the hold timeout.
      if (step_take) begin
         idle_next = '0;
      end else if (32'(idle_reg) < HOLD_CYCLES) begin
         idle_next = 16'(idle_reg + 16'h0001);
      end
      // Count accepted steps; a clear wins only when no step arrives.
      if (step_take) begin
         stepcnt_next = 16'(stepcnt_reg + 16'h0001);
      end else if (cnt_clear) begin
         stepcnt_next = `SSC_CNT_RESET;
      end
      unique case (state_reg)
         SSC_ACTIVE, SSC_HOLD: begin
            if (mode_sleep) begin
               state_next = SSC_COAST_PINS;
            end else if (pins_s.ref_above_threshold) begin
               state_next = SSC_COAST_REF;
            end else if (step_take) begin
               state_next = SSC_ACTIVE;
            end else if (32'(idle_reg) >= HOLD_CYCLES) begin
               state_next = SSC_HOLD;
            end
         end
         SSC_COAST_REF: begin
            if (mode_sleep) begin
               state_next = SSC_COAST_PINS;
            end else if (!pins_s.ref_above_threshold) begin
               state_next = SSC_ACTIVE;
            end
         end
         SSC_COAST_PINS: begin
            if (!mode_sleep) begin
               state_next = pins_s.ref_above_threshold ? SSC_COAST_REF : SSC_HOLD;
            end
         end
      endcase
   end

   // Power-on reset lands every sequencer register at home.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SSC_ACTIVE;
         pos_reg <= `SSC_HOME_POS;
         step_prev_reg <= 1'b1;
         idle_reg <= '0;
         stepcnt_reg <= `SSC_CNT_RESET;
         por_done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pos_reg <= pos_next;
         step_prev_reg <= step_prev_next;
         idle_reg <= idle_next;
         stepcnt_reg <= stepcnt_next;
         por_done_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------

   ssc_phase_dec u_dec (
      .pclk(pclk),
      .presetn(presetn),
      .position(pos_reg),
      .drive_en(drive_en),
      .phase_out(phase_drive)
   );

   logic [3:0] mon_reg; // Chop sync, supply reduce, position and alarm monitors.
   logic [3:0] mon_next;

   // Chop sync is a direct copy, the others are inverted, so the home position reads low.
   always_comb begin
      mon_next[0] = pins_s.hold_chop_align;
      mon_next[1] = ~drive_en;
      mon_next[2] = ~(pos_reg == `SSC_HOME_POS);
      mon_next[3] = ~pins_s.fault;
   end

   // Monitors idle inactive: home reads low, no alarm reads high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_reg <= 4'h8;
      end else begin
         mon_reg <= mon_next;
      end
   end

   assign chop_sync_en = mon_reg[0];
   assign supply_reduce = mon_reg[1];
   assign step_position_out_n = mon_reg[2];
   assign alarm_out_n = mon_reg[3];

   // ----------------------------------------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------------------------------------

   logic [1:0] ctrl_reg;       // Self-clearing control pulses.
   logic [1:0] ctrl_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic setup;                // Setup phase this cycle.
   logic wr_hit;               // Write completing this cycle.

   always_comb begin
      setup = psel & ~penable;
      wr_hit = psel & penable & pready_reg & pwrite & ~pslverr_reg;
      soft_home = ctrl_reg[`SSC_CTRL_HOME_BIT];
      cnt_clear = ctrl_reg[`SSC_CTRL_CNTCLR_BIT];
   end

   // Decode in the setup cycle so the answer is ready in the access cycle.
   always_comb begin
      pready_next = setup;
      pslverr_next = 1'b0;
      prdata_next = '0;
      ctrl_next = `SSC_CTRL_RESET;
      if (setup) begin
         unique case (paddr)
            `SSC_ADDR_CTRL: prdata_next = '0;
            `SSC_ADDR_STATUS: prdata_next = {24'h0, mode_sleep, pins_s.hold_chop_align, state_reg, 1'b0, pos_reg};
            `SSC_ADDR_STEPCNT: prdata_next = {16'h0, stepcnt_reg};
            default: pslverr_next = 1'b1;
         endcase
         if (pwrite) begin
            prdata_next = '0;
         end
      end
      if (wr_hit && paddr == `SSC_ADDR_CTRL) begin
         ctrl_next = pwdata[1:0];
      end
   end

   // Bus outputs start idle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `SSC_CTRL_RESET;
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------

   property p_por_home;
      @(posedge pclk) disable iff (!presetn) !por_done_reg |-> pos_reg == `SSC_HOME_POS;
   endproperty
   a_por_home: assert property (p_por_home) else $error("Not home after power-on.");

   property p_pin_home;
      @(posedge pclk) disable iff (!presetn) pins_s.reset_pin |=> pos_reg == `SSC_HOME_POS;
   endproperty
   a_pin_home: assert property (p_pin_home) else $error("Reset pin did not home.");

   property p_hold_idle;
      @(posedge pclk) disable iff (!presetn) !step_rise && !home_req |=> $stable(pos_reg);
   endproperty
   a_hold_idle: assert property (p_hold_idle) else $error("Position moved without edge.");

   property p_one_step;
      @(posedge pclk) disable iff (!presetn)
         step_take |=> pos_reg == step_pos($past(pos_reg), $past(pins_s.direction_select),
            $past(pins_s.excitation_mode_sel));
   endproperty
   a_one_step: assert property (p_one_step) else $error("Step was not exactly one.");

   property p_chop;
      @(posedge pclk) disable iff (!presetn) pins_s.hold_chop_align |=> chop_sync_en;
   endproperty
   a_chop: assert property (p_chop) else $error("Chop sync not enabled.");

   property p_ref_coast;
      @(posedge pclk) disable iff (!presetn)
         pins_s.ref_above_threshold |=> phase_drive == `SSC_PHASE_OFF && supply_reduce;
   endproperty
   a_ref_coast: assert property (p_ref_coast) else $error("Reference coast left drives on.");

   property p_ref_steps;
      @(posedge pclk) disable iff (!presetn)
         pins_s.ref_above_threshold && step_take |=> pos_reg != $past(pos_reg);
   endproperty
   a_ref_steps: assert property (p_ref_steps) else $error("Sequencer stopped in reference coast.");

   property p_pin_coast;
      @(posedge pclk) disable iff (!presetn)
         mode_sleep |=> state_reg == SSC_COAST_PINS && phase_drive == `SSC_PHASE_OFF;
   endproperty
   a_pin_coast: assert property (p_pin_coast) else $error("Mode sleep did not coast.");

   property p_sleep_ignore;
      @(posedge pclk) disable iff (!presetn) mode_sleep && !home_req |=> $stable(pos_reg);
   endproperty
   a_sleep_ignore: assert property (p_sleep_ignore) else $error("Step taken in mode sleep.");

   property p_monitor;
      @(posedge pclk) disable iff (!presetn) pos_reg == `SSC_HOME_POS |=> !step_position_out_n;
   endproperty
   a_monitor: assert property (p_monitor) else $error("Home monitor not low.");

endmodule

`default_nettype wire

// [verif/ssc_mcu_model.sv]
// Behavioural model of the controller that drives the step and control pins.
// Assumes the bench calls its tasks from one process and that pclk runs.
`timescale 1ns/1ps
`default_nettype none

module ssc_mcu_model (
   // Clock.
   input wire logic pclk,
   // Pins towards the sequencer.
   output logic step_clock,
   output logic reset_pin,
   output logic direction_select,
   output logic [2:0] excitation_mode_sel,
   output logic hold_chop_align
);
   // -------------------------------------------------------------------
   // Pin start values
   // -------------------------------------------------------------------
   // Every pin is driven from time zero, so none floats.
   initial begin
      step_clock = 1'b0;
      reset_pin = 1'b0;
      direction_select = 1'b0;
      excitation_mode_sel = 3'h0;
      hold_chop_align = 1'b0;
   end

   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   // Lets a number of clock edges pass.
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Sets the level pins, then waits before any step so the block settles.
   task automatic set_levels(input logic dir, input logic [2:0] mode, input logic chop);
      @(posedge pclk);
      direction_select <= dir;
      excitation_mode_sel <= mode;
      hold_chop_align <= chop;
      wait_cyc(8);
   endtask

   // Gives n rising step edges, each level held four cycles.
   task automatic pulse(input int n, input logic end_high);
      @(posedge pclk);
      hold_chop_align <= 1'b0;
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         step_clock <= 1'b0;
         wait_cyc(3);
         @(posedge pclk);
         step_clock <= 1'b1;
         wait_cyc(3);
      end
      if (!end_high) begin
         @(posedge pclk);
         step_clock <= 1'b0;
      end
   endtask

   // Acts as the clock-loss detector: chop align rises once the step clock stays low n cycles.
   task automatic loss_detect(input int n);
      int idle;
      idle = 0;
      while (idle < n) begin
         @(posedge pclk);
         idle = step_clock ? 0 : idle + 1;
      end
      hold_chop_align <= 1'b1;
   endtask

   // Pulses the reset pin to send the sequencer home.
   task automatic homing();
      @(posedge pclk);
      reset_pin <= 1'b1;
      wait_cyc(4);
      @(posedge pclk);
      reset_pin <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the step sequencer control block.
// Assumes the package, the constants header and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.svh"

module tb;
   import ssc_pkg::*;
   // -------------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------------
   typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} ssc_tb_note_t;
   logic pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, step_clock, reset_pin, dir_pin, chop_pin, ref_in, fault;
   logic [2:0] mode_pin, exp_pos;
   logic [3:0] phase_drive;
   logic chop_sync_en, supply_reduce, pos_n, alarm_n;
   int bad_count, compares, exp_cnt, n;
   ssc_tb_note_t notes[$];
   ssc_tb_note_t cur;

   // Clock of 50 ns period.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // -------------------------------------------------------------------
   // Design and controller model
   // -------------------------------------------------------------------
   ssc_top #(.HOLD_CYCLES(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .step_clock_in(step_clock), .reset_pin_in(reset_pin),
      .direction_select_in(dir_pin), .excitation_mode_sel_in(mode_pin),
      .hold_chop_align_in(chop_pin), .reference_and_disable_input(ref_in), .fault_in(fault),
      .phase_drive(phase_drive), .chop_sync_en(chop_sync_en), .supply_reduce(supply_reduce),
      .step_position_out_n(pos_n), .alarm_out_n(alarm_n));
   ssc_mcu_model mcu (.pclk(pclk), .step_clock(step_clock), .reset_pin(reset_pin),
      .direction_select(dir_pin), .excitation_mode_sel(mode_pin), .hold_chop_align(chop_pin));

   // -------------------------------------------------------------------
   // Checking tasks
   // -------------------------------------------------------------------
   // Counts and reports one mismatch.
   task automatic fail(input string msg);
      bad_count++;
      $display("FAIL %0t %s", $time, msg);
   endtask

   // Compares a pin output with its expected level.
   task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
      compares++;
      if (got !== exp) fail("pin output differs");
   endtask

   // Compares one finished read with the oldest note.
   task automatic cmp_read(input ssc_tb_note_t e);
      compares++;
      if (((prdata & e.mask) !== (e.data & e.mask)) || (pslverr !== e.err)) fail("read differs");
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watches the bus and takes the oldest note when read data appears.
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         if (notes.size() == 0) begin
            fail("read without note");
         end else begin
            cur = notes.pop_front();
            cmp_read(cur);
         end
      end
   end

   // -------------------------------------------------------------------
   // Bus and stimulus tasks
   // -------------------------------------------------------------------
   // One APB transfer: setup, then access until pready is seen high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) fail("no ready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Notes the expected read and starts it.
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
      notes.push_back('{d, m, e});
      apb(1'b0, a, $urandom());
   endtask

   // Expected status word.
   function automatic logic [31:0] st(input logic [2:0] p, input logic [1:0] s, input logic sl);
      return {24'h0, sl, 1'b0, s, 1'b0, p};
   endfunction

   // Steps and tracks the expected position; sleep steps are not counted.
   task automatic step_n(input int cnt, input logic end_high, input logic counted);
      int sz;
      sz = (mode_pin == `SSC_MODE_HALF) ? 1 : 2;
      mcu.pulse(cnt, end_high);
      if (counted) begin
         exp_pos = 3'(int'(exp_pos) + (dir_pin ? -sz * cnt : sz * cnt));
         exp_cnt += cnt;
      end
      mcu.wait_cyc(6);
   endtask

   // Watchdog far beyond the expected run length.
   initial begin
      #2000000;
      fail("timeout");
      report_and_stop();
   end

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, ref_in, fault} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      bad_count = 0;
      compares = 0;
      exp_cnt = 0;
      exp_pos = 3'h0;
      void'($urandom(32'h982E4091));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      mcu.wait_cyc(4);
      // Home state after power-on, monitors inverted.
      cmp_pin(phase_drive, 4'h1);
      cmp_pin({3'h0, pos_n}, 4'h0);
      cmp_pin({3'h0, alarm_n}, 4'h1);
      rd(`SSC_ADDR_STATUS, 32'h0, 32'h7, 1'b0);
      rd(`SSC_ADDR_CTRL, 32'h0, 32'hFFFFFFFF, 1'b0);
      rd(12'h00C, 32'h0, 32'hFFFFFFFF, 1'b1);
      // Random step runs in modes 0 to 2, then random modes up to 6, in both directions.
      apb(1'b1, `SSC_ADDR_CTRL, {30'($urandom()), 2'h2});
      for (int i = 0; i < 8; i++) begin
         mcu.set_levels(i[0], (i < 3) ? 3'(i) : 3'($urandom_range(0, 6)), 1'b0);
         step_n($urandom_range(1, 7), 1'b0, 1'b1);
         rd(`SSC_ADDR_STATUS, {29'h0, exp_pos}, 32'h7, 1'b0);
      end
      rd(`SSC_ADDR_STEPCNT, exp_cnt, 32'hFFFF, 1'b0);
      // Count clear from software empties the step counter.
      apb(1'b1, `SSC_ADDR_CTRL, {30'($urandom()), 2'h2});
      exp_cnt = 0;
      rd(`SSC_ADDR_STEPCNT, 32'h0, 32'hFFFF, 1'b0);
      // Clock stops high, then low: position held and state goes to hold.
      for (int i = 1; i >= 0; i--) begin
         step_n(1, i[0], 1'b1);
         mcu.wait_cyc(30);
         rd(`SSC_ADDR_STATUS, st(exp_pos, SSC_HOLD, 1'b0), 32'hB7, 1'b0);
      end
      // Chop align while holding.
      mcu.loss_detect(12);
      mcu.wait_cyc(4);
      cmp_pin({3'h0, chop_sync_en}, 4'h1);
      rd(`SSC_ADDR_STATUS, 32'h40, 32'h40, 1'b0);
      mcu.set_levels(dir_pin, mode_pin, 1'b0);
      cmp_pin({3'h0, chop_sync_en}, 4'h0);
      // Alarm monitor follows a random fault level, then its inverse.
      n = $urandom_range(0, 1);
      for (int i = 0; i < 2; i++) begin
         fault <= n[0] ^ i[0];
         mcu.wait_cyc(5);
         cmp_pin({3'h0, alarm_n}, {3'h0, ~(n[0] ^ i[0])});
      end
      fault <= 1'b0;
      // Reference coast: outputs off, sequencer keeps stepping.
      ref_in <= 1'b1;
      mcu.wait_cyc(5);
      cmp_pin(phase_drive, 4'h0);
      cmp_pin({3'h0, supply_reduce}, 4'h1);
      step_n(2, 1'b0, 1'b1);
      rd(`SSC_ADDR_STATUS, st(exp_pos, SSC_COAST_REF, 1'b0), 32'hB7, 1'b0);
      ref_in <= 1'b0;
      // Mode-pin sleep: outputs off, step edges ignored.
      mcu.set_levels(1'b0, `SSC_MODE_SLEEP, 1'b0);
      cmp_pin(phase_drive, 4'h0);
      cmp_pin({3'h0, supply_reduce}, 4'h1);
      step_n(3, 1'b0, 1'b0);
      rd(`SSC_ADDR_STATUS, st(exp_pos, SSC_COAST_PINS, 1'b1), 32'hB7, 1'b0);
      rd(`SSC_ADDR_STEPCNT, exp_cnt, 32'hFFFF, 1'b0);
      mcu.set_levels(1'b0, 3'h0, 1'b0);
      cmp_pin({3'h0, supply_reduce}, 4'h0);
      // Reset pin, then the home bit, each return the sequencer home.
      step_n(1, 1'b0, 1'b1);
      mcu.homing();
      mcu.wait_cyc(6);
      rd(`SSC_ADDR_STATUS, 32'h0, 32'h7, 1'b0);
      cmp_pin({3'h0, pos_n}, 4'h0);
      exp_pos = 3'h0;
      step_n(1, 1'b0, 1'b1);
      cmp_pin({3'h0, pos_n}, 4'h1);
      apb(1'b1, `SSC_ADDR_CTRL, {30'($urandom()), 2'h1});
      exp_pos = 3'h0;
      mcu.wait_cyc(4);
      rd(`SSC_ADDR_STATUS, 32'h0, 32'h7, 1'b0);
      // Reset in mid-run brings the position home again.
      step_n(2, 1'b0, 1'b1);
      presetn <= 1'b0;
      mcu.wait_cyc(2);
      presetn <= 1'b1;
      mcu.wait_cyc(4);
      rd(`SSC_ADDR_STATUS, 32'h0, 32'h7, 1'b0);
      mcu.wait_cyc(3);
      report_and_stop();
   end
endmodule
`default_nettype wire
